// File: inc/bls_cfg.svh
// Constants for the board status LED sequencer: register map, fields and timing.
`ifndef BLS_CFG_SVH
`define BLS_CFG_SVH
`define BLS_CLK_HZ        50000000
`define BLS_STEP_MS       100
`define BLS_STEP_CYC      ((`BLS_CLK_HZ / 1000) * `BLS_STEP_MS)
`define BLS_FRAME_STEPS   8
`define BLS_SEQ_COUNT     6
`define BLS_OFF_CTRL      12'h000
`define BLS_OFF_STAT      12'h004
`define BLS_OFF_IRQ_STAT  12'h008
`define BLS_OFF_IRQ_MASK  12'h00C
`define BLS_PAT1          8'h05
`define BLS_PAT2          8'h0F
`define BLS_PAT3          8'h55
`define BLS_PAT4          8'h01
`define BLS_PAT5          8'h33
`define BLS_PAT6          8'h15
`define BLS_SEQ_RST       3'h2
`define BLS_IRQ_W         3
`define BLS_IRQ_SEQ_CHG   0
`define BLS_IRQ_SHORT     1
`define BLS_IRQ_REG_FAIL  2
`endif

// File: inc/bls_pkg.sv
// Types shared by the board status LED sequencer.
package bls_pkg;
  typedef struct packed {
    logic proc_one_regulator_ok_led;
    logic proc_zero_regulator_ok_led;
    logic fetch_led;
    logic over_current_led;
    logic fan_led;
    logic supply_led;
  } bls_leds_t;

  typedef struct packed {
    logic proc_one_reg_ok;
    logic proc_zero_reg_ok;
    logic proc_one_fetch;
    logic proc_zero_fetch;
    logic short_det;
  } bls_sense_t;

  typedef enum logic [1:0] {
    BLS_ST_IDLE = 2'b01,
    BLS_ST_ACC  = 2'b10
  } bls_apb_st_t;
endpackage

// File: verilog/bls_led_seq.sv
// Board status LED sequencer with APB register access and an interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "bls_cfg.svh"
// Notes on behaviour
// - The fan LED pattern advances in 0.1 s steps, each step lit or dark.
// - Exactly six selectable sequences; one to three normal, four to six errors.
// - Sequence one is the heartbeat: on, off, on, five off steps.
// - Sequence two shows while the controller powers up.
// - Sequence three is a further transient indication, no system fault.
// - Sequence four, one on step then seven off, marks over-temperature shutdown.
// - Sequence five marks a failed fan.
// - Sequence six marks a general error.
// - A healthy sequencer keeps toggling the fan LED, never freezing it.
// - Processor-one regulator LED is lit while that regulator works.
// - Processor-zero regulator LED is lit while that regulator works.
// - Fetch LED is lit while either processor fetches code.
// - Over-current LED is lit when a short is detected, dark otherwise.
// - The supply LED output is reserved and carries no status.
module bls_led_seq
  import bls_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire bls_sense_t  sense_i,
  output bls_leds_t        leds_o,
  output logic             irq_o
);

  // Two-flop synchronisers for the asynchronous sense pins.
  bls_sense_t sense_s1_r;
  bls_sense_t sense_s2_r;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sense_s1_r <= '0;
      sense_s2_r <= '0;
    end
    else
    begin
      sense_s1_r <= sense_i;
      sense_s2_r <= sense_s1_r;
    end
  end

  // Register state and next values.
  logic [2:0]              seq_sel_r, seq_sel_nxt;
  logic [`BLS_IRQ_W-1:0]   irq_stat_r, irq_stat_nxt;
  logic [`BLS_IRQ_W-1:0]   irq_mask_r, irq_mask_nxt;
  logic [31:0]             prdata_r, prdata_nxt;
  logic                    short_q_r, short_q_nxt;
  logic                    regok_q_r, regok_q_nxt;
  logic [22:0]             step_cnt_r, step_cnt_nxt;
  logic [2:0]              step_idx_r, step_idx_nxt;
  logic                    fan_r, fan_nxt;
  logic                    seq_chg;
  logic                    step_en;
  logic                    wr_en;
  logic                    rd_en;
  logic [7:0]              pat;
  logic                    regok_now;

  // Every access is zero-wait. Read data is captured at the setup edge, so it
  // already stands on prdata_o through the access phase and is valid at the
  // edge where the master samples pready; a write lands at the access edge.
  assign pready_o  = 1'b1;
  assign wr_en     = psel_i & penable_i & pwrite_i;
  assign rd_en     = psel_i & ~penable_i & ~pwrite_i;
  assign regok_now = sense_s2_r.proc_one_reg_ok & sense_s2_r.proc_zero_reg_ok;

  // Unmapped addresses answer with an error and write nothing.
  always_comb
  begin
    pslverr_o = 1'b0;
    if (psel_i && penable_i)
    begin
      case (paddr_i)
        `BLS_OFF_CTRL, `BLS_OFF_STAT, `BLS_OFF_IRQ_STAT, `BLS_OFF_IRQ_MASK:
          pslverr_o = 1'b0;
        default:
          pslverr_o = 1'b1;
      endcase
    end
  end

  // Pattern of the sequence in force next cycle; bit n is step n, a set bit
  // lights the LED. Looking at the next selection lets a new sequence open on
  // its own first step rather than on a step of the old one.
  always_comb
  begin
    case (seq_sel_nxt)
      3'h1:    pat = `BLS_PAT1;
      3'h2:    pat = `BLS_PAT2;
      3'h3:    pat = `BLS_PAT3;
      3'h4:    pat = `BLS_PAT4;
      3'h5:    pat = `BLS_PAT5;
      3'h6:    pat = `BLS_PAT6;
      default: pat = `BLS_PAT1;
    endcase
  end

  // Register file, sticky interrupt flags and read data.
  always_comb
  begin
    seq_sel_nxt  = seq_sel_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    prdata_nxt   = prdata_r;
    short_q_nxt  = sense_s2_r.short_det;
    regok_q_nxt  = regok_now;
    seq_chg      = 1'b0;
    if (wr_en && paddr_i == `BLS_OFF_CTRL)
    begin
      // Only values one to six select a sequence; others are ignored.
      if (pwdata_i[2:0] >= 3'h1 && pwdata_i[2:0] <= 3'(`BLS_SEQ_COUNT))
      begin
        seq_sel_nxt = pwdata_i[2:0];
        seq_chg     = 1'b1;
      end
    end
    if (wr_en && paddr_i == `BLS_OFF_IRQ_MASK)
      irq_mask_nxt = pwdata_i[`BLS_IRQ_W-1:0];
    // Write one to clear; a new event in the same cycle wins.
    if (wr_en && paddr_i == `BLS_OFF_IRQ_STAT)
      irq_stat_nxt = irq_stat_nxt & ~pwdata_i[`BLS_IRQ_W-1:0];
    if (seq_chg)
      irq_stat_nxt[`BLS_IRQ_SEQ_CHG] = 1'b1;
    if (sense_s2_r.short_det && !short_q_r)
      irq_stat_nxt[`BLS_IRQ_SHORT] = 1'b1;
    if (!regok_now && regok_q_r)
      irq_stat_nxt[`BLS_IRQ_REG_FAIL] = 1'b1;
    if (rd_en)
    begin
      case (paddr_i)
        `BLS_OFF_CTRL:     prdata_nxt = {29'h0, seq_sel_r};
        `BLS_OFF_STAT:     prdata_nxt = {21'h0, step_idx_r, fan_r, leds_o[5:2], 2'h0,
                                          sense_s2_r.short_det};
        `BLS_OFF_IRQ_STAT: prdata_nxt = {29'h0, irq_stat_r};
        `BLS_OFF_IRQ_MASK: prdata_nxt = {29'h0, irq_mask_r};
        default:           prdata_nxt = 32'h0;
      endcase
    end
  end

  // Step timer and blink sequencer.
  assign step_en = (step_cnt_r == 23'(`BLS_STEP_CYC - 1));
  always_comb
  begin
    step_cnt_nxt = step_en ? 23'h0 : step_cnt_r + 23'h1;
    step_idx_nxt = step_idx_r;
    fan_nxt      = fan_r;
    if (seq_chg)
    begin
      // A new sequence restarts at its first step.
      step_cnt_nxt = 23'h0;
      step_idx_nxt = 3'h0;
      fan_nxt      = pat[0];
    end
    else if (step_en)
    begin
      // Index wraps after eight steps so the frame repeats without a gap.
      step_idx_nxt = step_idx_r + 3'h1;
      fan_nxt      = pat[step_idx_nxt];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      seq_sel_r  <= `BLS_SEQ_RST;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      prdata_r   <= 32'h0;
      short_q_r  <= 1'b0;
      regok_q_r  <= 1'b0;
      step_cnt_r <= 23'h0;
      step_idx_r <= 3'h0;
      fan_r      <= 1'b1;
    end
    else
    begin
      seq_sel_r  <= seq_sel_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      prdata_r   <= prdata_nxt;
      short_q_r  <= short_q_nxt;
      regok_q_r  <= regok_q_nxt;
      step_cnt_r <= step_cnt_nxt;
      step_idx_r <= step_idx_nxt;
      fan_r      <= fan_nxt;
    end
  end

  // Status LEDs follow the synchronised sense pins; the fan LED takes the
  // sequencer's next value so that it moves on the same edge as fan_r.
  bls_leds_t leds_r;
  bls_leds_t leds_nxt;
  always_comb
  begin
    leds_nxt.proc_one_regulator_ok_led  = sense_s2_r.proc_one_reg_ok;
    leds_nxt.proc_zero_regulator_ok_led = sense_s2_r.proc_zero_reg_ok;
    leds_nxt.fetch_led        = sense_s2_r.proc_one_fetch | sense_s2_r.proc_zero_fetch;
    leds_nxt.over_current_led = sense_s2_r.short_det;
    leds_nxt.fan_led          = fan_nxt;
    leds_nxt.supply_led       = 1'b0;
  end

  // Registered LED outputs; every light is dark while reset is held.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      leds_r <= '0;
    else
      leds_r <= leds_nxt;
  end

  assign leds_o   = leds_r;
  assign prdata_o = prdata_r;
  assign irq_o    = |(irq_stat_r & irq_mask_r);

  // Assertions.
  // The heartbeat or the over-temperature sequence is in force.
  sequence s_on_heartbeat;
    seq_sel_r == 3'h1;
  endsequence
  sequence s_on_overtemp;
    seq_sel_r == 3'h4;
  endsequence
  // A step ends with no new selection in the same cycle.
  sequence s_step_end;
    step_en && !seq_chg;
  endsequence
  // The first cycle of the first step of a frame.
  sequence s_first_step;
    step_idx_r == 3'h0 && step_cnt_r == 23'h0;
  endsequence

  chk_hb_pattern: assert property (@(posedge clk_i) disable iff (rst_i)
    s_on_heartbeat |-> fan_r == 1'(`BLS_PAT1 >> step_idx_r))
    else $error("Heartbeat pattern wrong.");
  chk_ovt_pattern: assert property (@(posedge clk_i) disable iff (rst_i)
    s_on_overtemp |-> fan_r == 1'(`BLS_PAT4 >> step_idx_r))
    else $error("Over-temperature pattern wrong.");
  chk_step_len: assert property (@(posedge clk_i) disable iff (rst_i)
    step_en |=> step_cnt_r == 23'h0)
    else $error("Step timer did not wrap.");
  chk_step_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    step_cnt_r <= 23'(`BLS_STEP_CYC - 1))
    else $error("Step timer ran past one step.");
  chk_step_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !step_en && !seq_chg |=> $stable(fan_r))
    else $error("Fan LED moved inside a step.");
  chk_step_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    s_step_end |=> step_idx_r == $past(step_idx_r) + 3'h1)
    else $error("Step index did not advance.");
  chk_seq_range: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_sel_r >= 3'h1 && seq_sel_r <= 3'(`BLS_SEQ_COUNT))
    else $error("Sequence selection out of range.");
  chk_seq_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_chg |=> s_first_step)
    else $error("New sequence did not restart.");
  chk_seq_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_chg |=> irq_stat_r[`BLS_IRQ_SEQ_CHG])
    else $error("Sequence change flag not set.");
  chk_short_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    sense_s2_r.short_det && !short_q_r |=> irq_stat_r[`BLS_IRQ_SHORT])
    else $error("Short flag not set.");
  chk_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_stat_r[`BLS_IRQ_SEQ_CHG]
      && !(wr_en && paddr_i == `BLS_OFF_IRQ_STAT && pwdata_i[`BLS_IRQ_SEQ_CHG])
      |=> irq_stat_r[`BLS_IRQ_SEQ_CHG])
    else $error("Status flag dropped without a clear.");
  chk_frame_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    step_en && !seq_chg && step_idx_r == 3'h7 |=> step_idx_r == 3'h0)
    else $error("Frame did not repeat.");
  chk_short_led: assert property (@(posedge clk_i) disable iff (rst_i)
    sense_s2_r.short_det |=> leds_o.over_current_led)
    else $error("Over-current LED not lit.");
  chk_short_dark: assert property (@(posedge clk_i) disable iff (rst_i)
    !sense_s2_r.short_det |=> !leds_o.over_current_led)
    else $error("Over-current LED lit without a short.");
  chk_fetch_on: assert property (@(posedge clk_i) disable iff (rst_i)
    sense_s2_r.proc_one_fetch || sense_s2_r.proc_zero_fetch |=> leds_o.fetch_led)
    else $error("Fetch LED dark during fetch.");
  chk_fetch_led: assert property (@(posedge clk_i) disable iff (rst_i)
    !(sense_s2_r.proc_one_fetch | sense_s2_r.proc_zero_fetch) |=> !leds_o.fetch_led)
    else $error("Fetch LED lit without fetch.");
  chk_regok_leds: assert property (@(posedge clk_i) disable iff (rst_i)
    sense_s2_r.proc_one_reg_ok |=> leds_o.proc_one_regulator_ok_led)
    else $error("Regulator LED not lit.");
  chk_regok0_led: assert property (@(posedge clk_i) disable iff (rst_i)
    sense_s2_r.proc_zero_reg_ok |=> leds_o.proc_zero_regulator_ok_led)
    else $error("Second regulator LED not lit.");
  chk_supply_dark: assert property (@(posedge clk_i) disable iff (rst_i)
    !leds_o.supply_led)
    else $error("Supply LED driven.");

endmodule
`default_nettype wire

// File: sim/bls_viewer.sv
// Model of the person who watches the board LEDs and notices fan blinks.
`timescale 1ns/1ps
`default_nettype none
module bls_viewer
  import bls_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire bls_leds_t leds_i,
  output logic    [31:0] fan_edges_o
);
  logic last_fan_r;
  // Counts each change of the fan light after reset, as an observer sees a blink.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      last_fan_r  <= 1'b0;
      fan_edges_o <= 32'h0;
    end
    else
    begin
      if (leds_i.fan_led != last_fan_r)
        fan_edges_o <= fan_edges_o + 32'h1;
      last_fan_r <= leds_i.fan_led;
    end
  end
endmodule
`default_nettype wire

// File: sim/test_board_status_led_sequencer.sv
// Self-checking testbench for the board status LED sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "bls_cfg.svh"
module test_board_status_led_sequencer
  import bls_pkg::*;
;
  logic        clk_i, rst_i, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, fan_edges;
  logic        e;
  bls_sense_t  sense;
  bls_leds_t   leds;
  int          num_errors, checks_done;
  logic [7:0]  pats [6] = '{`BLS_PAT1, `BLS_PAT2, `BLS_PAT3, `BLS_PAT4, `BLS_PAT5, `BLS_PAT6};

  bls_led_seq i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sense_i(sense), .leds_o(leds), .irq_o(irq));
  bls_viewer i_view (.clk_i(clk_i), .rst_i(rst_i), .leds_i(leds), .fan_edges_o(fan_edges));

  // Compares a value seen with the value expected and counts the check.
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer: a setup cycle, then the access phase until pready is
  // seen high; read data and the error flag are taken at that same edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do
      @(posedge clk_i);
    while (pready !== 1'b1);
    e       = pslverr;
    rv      = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset state and default lights.
  task t_reset;
    repeat (5) @(posedge clk_i);
    chk("leds", 32'(leds), 32'h3A);
    apb(1'b0, `BLS_OFF_CTRL, 32'h0);
    chk("ctrl", rv, 32'h2);
    chk("slverr", 32'(e), 32'h0);
  endtask

  // Every sequence is selectable and restarts at step zero; illegal codes are ignored.
  task t_seq;
    for (int s = 1; s <= `BLS_SEQ_COUNT; s++)
    begin
      apb(1'b1, `BLS_OFF_CTRL, 32'(s));
      apb(1'b0, `BLS_OFF_CTRL, 32'h0);
      chk("ctrl", rv, 32'(s));
      apb(1'b0, `BLS_OFF_STAT, 32'h0);
      chk("step", 32'(rv[10:7]), 32'({3'h0, pats[s-1][0]}));
    end
    apb(1'b1, `BLS_OFF_CTRL, 32'h0);
    apb(1'b1, `BLS_OFF_CTRL, 32'h7);
    apb(1'b0, `BLS_OFF_CTRL, 32'h0);
    chk("ctrl", rv, 32'h6);
    apb(1'b1, `BLS_OFF_CTRL, 32'h1);
  endtask

  // Sequence-change interrupt raised, cleared and masked.
  task t_irq;
    apb(1'b1, `BLS_OFF_IRQ_STAT, 32'h7);
    apb(1'b1, `BLS_OFF_IRQ_MASK, 32'h1);
    apb(1'b1, `BLS_OFF_CTRL, 32'h3);
    repeat (2) @(posedge clk_i);
    chk("irq_set", 32'(irq), 32'h1);
    apb(1'b1, `BLS_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq_clr", 32'(irq), 32'h0);
    apb(1'b1, `BLS_OFF_IRQ_MASK, 32'h0);
    apb(1'b1, `BLS_OFF_CTRL, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq_masked", 32'(irq), 32'h0);
    apb(1'b0, `BLS_OFF_IRQ_STAT, 32'h0);
    chk("irq_stat", rv, 32'h1);
  endtask

  // Failed regulator, fetch by one processor and a short.
  task t_sense;
    apb(1'b1, `BLS_OFF_IRQ_STAT, 32'h7);
    apb(1'b1, `BLS_OFF_IRQ_MASK, 32'h6);
    sense <= 5'h13;
    repeat (5) @(posedge clk_i);
    chk("leds", 32'(leds), 32'h2E);
    chk("irq", 32'(irq), 32'h1);
    apb(1'b0, `BLS_OFF_IRQ_STAT, 32'h0);
    chk("irq_stat", rv, 32'h6);
    apb(1'b0, `BLS_OFF_STAT, 32'h0);
    chk("stat", 32'({rv[6:3], rv[0]}), 32'h17);
    sense <= 5'h08;
    repeat (5) @(posedge clk_i);
    chk("leds", 32'(leds), 32'h12);
    apb(1'b1, `BLS_OFF_IRQ_MASK, 32'h0);
  endtask

  // Unmapped address is refused and changes nothing.
  task t_unmap;
    apb(1'b1, 12'h010, 32'h5);
    chk("slverr", 32'(e), 32'h1);
    apb(1'b0, `BLS_OFF_CTRL, 32'h0);
    chk("ctrl", rv, 32'h1);
    chk("fan", 32'(leds.fan_led), 32'h1);
    // Every pattern opens lit and no step has elapsed: one rise after reset only.
    chk("fan_edges", fan_edges, 32'h1);
  endtask

  // Prints the verdict and stops the run.
  task end_sim;
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Clock at 50 MHz.
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Watchdog cuts a hang short.
  initial
  begin
    #400000;
    num_errors++;
    end_sim();
  end

  // Main sequence.
  initial
  begin
    rst_i       = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h0;
    pwdata      = 32'h0;
    sense       = 5'h1E;
    num_errors  = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_seq();
    t_irq();
    t_sense();
    t_unmap();
    end_sim();
  end
endmodule
`default_nettype wire
